//--- rtl/pcfg_pkg.sv
// Shared constants and types for the PHY configuration and control register bank.
`default_nettype none
package pcfg_pkg;
  // Register indices; the byte address on the bus is four times the index.
  localparam logic [7:0] CONF3_IDX     = 8'h1e;
  localparam logic [7:0] CTRL_IDX      = 8'h1f;
  localparam logic [7:0] TPAIR_IDX     = 8'h25;
  localparam logic [7:0] XTMR_IDX      = 8'h2c;
  localparam logic [7:0] IRQ_STAT_IDX  = 8'h38;
  localparam logic [7:0] IRQ_MASK_IDX  = 8'h39;
  // Field positions of phy_config_three.
  localparam int CONF3_FD_BIT     = 11;
  localparam int CONF3_ROBUST_BIT = 9;
  localparam int CONF3_QUICK_BIT  = 8;
  localparam int CONF3_INTOE_BIT  = 7;
  localparam int CONF3_FORCE_BIT  = 6;
  localparam int CONF3_FAIL_BIT   = 2;
  localparam int CONF3_DONE_BIT   = 1;
  localparam int CONF3_LAUNCH_BIT = 0;
  // Field positions of device_reset_control.
  localparam int CTRL_FULL_BIT    = 15;
  localparam int CTRL_RESTART_BIT = 14;
  // Field positions of test_pair_control and crossover_timer_config.
  localparam int TPAIR_SEL_LSB = 5;
  localparam int XTMR_RSVD_LSB = 4;
  // Interrupt status bit positions.
  localparam int IRQ_CT_DONE_BIT = 0;
  localparam int IRQ_CT_FAIL_BIT = 1;
  localparam int IRQ_XO_LOCK_BIT = 2;
  localparam int IRQ_W           = 3;
  // Reset values.
  localparam logic        CT_DONE_RST    = 1'b1;
  localparam logic [7:0]  TPAIR_RSVD_RST = 8'h04;
  localparam logic [2:0]  TPAIR_SEL_RST  = 3'h0;
  localparam logic [11:0] XTMR_RSVD_RST  = 12'h141;
  localparam logic [3:0]  XTMR_CODE_RST  = 4'hf;
  // Timing.
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_TIME_NS    = 1000000;
  localparam int MS_CYCLES     = MS_TIME_NS / CLK_PERIOD_NS;
  localparam int XTMR_STEP_MS  = 32;
  // Link state seen by the register bank.
  typedef struct packed {
    logic partner_forced_100tx; // Partner runs forced 100BASE-TX.
    logic local_autoneg_en;     // Local auto-negotiation enabled.
    logic local_forced_100tx;   // Local side forced to 100BASE-TX.
    logic ieee_full_duplex;     // Duplex from standard resolution.
    logic energy_detect;        // Receive energy on the current pairing.
  } pcfg_link_t;
  // Captured AHB address phase.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] idx;
  } pcfg_cmd_t;
  typedef enum logic [1:0] {
    XO_HUNT = 2'b00,
    XO_LOCK = 2'b01
  } pcfg_xo_state_t;
endpackage
`default_nettype wire

//--- rtl/pcfg_regs.sv
// PHY configuration and control register bank with AHB-Lite slave, crossover hunter and cable-test control.
`default_nettype none
// Overview of operation
// - Extended duplex bit forces full duplex against a forced 100BASE-TX partner.
// - With extended duplex off, duplex follows standard resolution.
// - Robust crossover bit selects robust resolution, otherwise normal automatic mode.
// - Robust mode keeps hunting in pairings where normal mode would deadlock.
// - Quick crossover bit shortens resolution when both ends are forced 100BASE-TX.
// - Pin role bit makes the shared pin an interrupt output or power-down input.
// - Force bit asserts the interrupt pin regardless of status, when the pin role is interrupt output.
// - Reserved bits 5:3 ignore writes and read zero.
// - Writing one to the launch bit starts a cable test.
// - Test complete is read-only, resets to one, zero while testing.
// - Test failed is read-only and reads one after a failed test.
// - Full soft reset returns every register to default, then clears itself.
// - Soft restart resets the engine but keeps registers, then clears itself.
// - Top select bit drives test mode on all four pairs.
// - Otherwise bits 6:5 pick one pair, A through D.
// - Timer code 0, 1, 2 give 32, 64, 96 ms slots.
module pcfg_regs #(
  parameter int         MS_CYCLES      = pcfg_pkg::MS_CYCLES, // Clock cycles per millisecond tick.
  parameter logic [9:0] NORMAL_SLOT_MS = 10'd64,              // Normal crossover slot length.
  parameter logic [9:0] QUICK_SLOT_MS  = 10'd8                // Quick crossover slot length.
) (
  input  wire logic               clk,                  // 100 MHz clock.
  input  wire logic               reset_n,              // Asynchronous reset, active low.
  input  wire logic               hsel,                 // AHB slave select.
  input  wire logic [31:0]        haddr,                // AHB address.
  input  wire logic [1:0]         htrans,               // AHB transfer type.
  input  wire logic               hwrite,               // AHB write.
  input  wire logic [2:0]         hsize,                // AHB size, word only.
  input  wire logic [31:0]        hwdata,               // AHB write data.
  input  wire logic               hready,               // AHB bus ready.
  output logic                    hreadyout,            // AHB slave ready.
  output logic                    hresp,                // AHB response, always OKAY.
  output logic [31:0]             hrdata,               // AHB read data.
  input  wire pcfg_pkg::pcfg_link_t link,               // Link state.
  input  wire logic               cable_test_finish,    // Test engine finished, one-cycle pulse.
  input  wire logic               cable_test_fault,     // Test result, valid with finish.
  input  wire logic               irq_or_powerdown_pin_i, // Shared pin level in.
  output logic                    irq_or_powerdown_pin_o, // Shared pin level out, low asserts interrupt.
  output logic                    irq_or_powerdown_pin_oe, // Shared pin output enable.
  output logic                    powerdown_req,        // Power-down requested through the pin.
  output logic                    link_full_duplex,     // Resolved duplex.
  output logic                    mdix_sel,             // Crossover selection, 1 is MDIX.
  output logic                    cable_test_run,       // Cable test engine running.
  output logic [3:0]              test_pair_en,         // Test mode enable per pair A to D.
  output logic                    core_reset,           // One-cycle reset to the PHY core.
  output logic                    irq                   // Level interrupt.
);
  localparam int MS_W = $clog2(MS_CYCLES);

  // Bus slave. Reads take one wait state so that a write just before is seen.
  pcfg_pkg::pcfg_cmd_t cmd_q;
  logic                hreadyout_q;
  logic [31:0]         hrdata_q;
  logic                take;
  logic                wr_conf3, wr_ctrl, wr_tpair, wr_xtmr, wr_stat, wr_mask;

  assign take     = hsel && hready && htrans[1];
  assign wr_conf3 = cmd_q.wr && (cmd_q.idx == pcfg_pkg::CONF3_IDX);
  assign wr_ctrl  = cmd_q.wr && (cmd_q.idx == pcfg_pkg::CTRL_IDX);
  assign wr_tpair = cmd_q.wr && (cmd_q.idx == pcfg_pkg::TPAIR_IDX);
  assign wr_xtmr  = cmd_q.wr && (cmd_q.idx == pcfg_pkg::XTMR_IDX);
  assign wr_stat  = cmd_q.wr && (cmd_q.idx == pcfg_pkg::IRQ_STAT_IDX);
  assign wr_mask  = cmd_q.wr && (cmd_q.idx == pcfg_pkg::IRQ_MASK_IDX);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_q       <= '0;
      hreadyout_q <= 1'b1;
    end else if (take) begin
      cmd_q.wr    <= hwrite;
      cmd_q.rd    <= !hwrite;
      cmd_q.idx   <= haddr[9:2];
      hreadyout_q <= hwrite;
    end else begin
      cmd_q.wr    <= 1'b0;
      cmd_q.rd    <= 1'b0;
      hreadyout_q <= 1'b1;
    end
  end

  // Configuration storage.
  logic        fd_q, robust_q, quick_q, intoe_q, force_q, launch_q;
  logic        full_rst_q, restart_q;
  logic [2:0]  tpair_sel_q;
  logic [11:0] xtmr_rsvd_q;
  logic [3:0]  xtmr_code_q;
  logic [pcfg_pkg::IRQ_W-1:0] stat_q, mask_q, events;
  logic        eng_rst;

  assign eng_rst = full_rst_q || restart_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fd_q     <= 1'b0;
      robust_q <= 1'b0;
      quick_q  <= 1'b0;
      intoe_q  <= 1'b0;
      force_q  <= 1'b0;
      launch_q <= 1'b0;
    end else if (full_rst_q) begin
      fd_q     <= 1'b0;
      robust_q <= 1'b0;
      quick_q  <= 1'b0;
      intoe_q  <= 1'b0;
      force_q  <= 1'b0;
      launch_q <= 1'b0;
    end else if (wr_conf3) begin
      fd_q     <= hwdata[pcfg_pkg::CONF3_FD_BIT];
      robust_q <= hwdata[pcfg_pkg::CONF3_ROBUST_BIT];
      quick_q  <= hwdata[pcfg_pkg::CONF3_QUICK_BIT];
      intoe_q  <= hwdata[pcfg_pkg::CONF3_INTOE_BIT];
      force_q  <= hwdata[pcfg_pkg::CONF3_FORCE_BIT];
      launch_q <= hwdata[pcfg_pkg::CONF3_LAUNCH_BIT];
    end
  end

  // Both reset strobes read back as one only for the cycle they act.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      full_rst_q <= 1'b0;
      restart_q  <= 1'b0;
      core_reset <= 1'b0;
    end else begin
      full_rst_q <= wr_ctrl && hwdata[pcfg_pkg::CTRL_FULL_BIT] && !full_rst_q;
      restart_q  <= wr_ctrl && hwdata[pcfg_pkg::CTRL_RESTART_BIT] && !full_rst_q;
      core_reset <= wr_ctrl && (hwdata[pcfg_pkg::CTRL_FULL_BIT] || hwdata[pcfg_pkg::CTRL_RESTART_BIT]);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tpair_sel_q <= pcfg_pkg::TPAIR_SEL_RST;
      xtmr_rsvd_q <= pcfg_pkg::XTMR_RSVD_RST;
      xtmr_code_q <= pcfg_pkg::XTMR_CODE_RST;
    end else if (full_rst_q) begin
      tpair_sel_q <= pcfg_pkg::TPAIR_SEL_RST;
      xtmr_rsvd_q <= pcfg_pkg::XTMR_RSVD_RST;
      xtmr_code_q <= pcfg_pkg::XTMR_CODE_RST;
    end else begin
      if (wr_tpair) begin
        tpair_sel_q <= hwdata[pcfg_pkg::TPAIR_SEL_LSB +: 3];
      end
      if (wr_xtmr) begin
        xtmr_rsvd_q <= hwdata[pcfg_pkg::XTMR_RSVD_LSB +: 12];
        xtmr_code_q <= hwdata[3:0];
      end
    end
  end

  // Cable test control.
  logic ct_run_q, ct_done_q, ct_fail_q;
  logic ct_start;

  assign ct_start = wr_conf3 && hwdata[pcfg_pkg::CONF3_LAUNCH_BIT] && !ct_run_q && !eng_rst;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ct_run_q  <= 1'b0;
      ct_done_q <= pcfg_pkg::CT_DONE_RST;
      ct_fail_q <= 1'b0;
    end else if (eng_rst) begin
      ct_run_q  <= 1'b0;
      ct_done_q <= pcfg_pkg::CT_DONE_RST;
      ct_fail_q <= 1'b0;
    end else if (ct_start) begin
      ct_run_q  <= 1'b1;
      ct_done_q <= 1'b0;
      ct_fail_q <= 1'b0;
    end else if (ct_run_q && cable_test_finish) begin
      ct_run_q  <= 1'b0;
      ct_done_q <= 1'b1;
      ct_fail_q <= cable_test_fault;
    end
  end

  assign cable_test_run = ct_run_q;

  // Millisecond tick for the crossover slot timer.
  logic [MS_W-1:0] ms_cnt_q;
  logic            ms_tick;

  assign ms_tick = (ms_cnt_q == MS_W'(MS_CYCLES - 1));

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ms_cnt_q <= '0;
    end else if (eng_rst || ms_tick) begin
      ms_cnt_q <= '0;
    end else begin
      ms_cnt_q <= ms_cnt_q + MS_W'(1);
    end
  end

  // Crossover hunter. Normal mode stalls in pairings it cannot resolve, as the standard hunter would.
  pcfg_pkg::pcfg_xo_state_t xo_q;
  logic [9:0] slot_cnt_q;
  logic [9:0] slot_ms;
  logic       quick_case, deadlock, hunt_en, slot_hit, xo_lock_ev;

  assign quick_case = quick_q && link.local_forced_100tx && !link.local_autoneg_en && link.partner_forced_100tx;
  assign deadlock   = link.partner_forced_100tx && (link.local_autoneg_en || link.local_forced_100tx);
  assign hunt_en    = robust_q || quick_case || !deadlock;
  assign slot_hit   = (xo_q == pcfg_pkg::XO_HUNT) && hunt_en && ms_tick && !link.energy_detect &&
                      (slot_cnt_q >= slot_ms - 10'd1);
  assign xo_lock_ev = (xo_q == pcfg_pkg::XO_HUNT) && link.energy_detect && !eng_rst;

  // The timer field only matters in robust mode; each code step adds one 32 ms slot.
  always_comb begin
    if (quick_case) begin
      slot_ms = QUICK_SLOT_MS;
    end else if (robust_q) begin
      slot_ms = {5'(xtmr_code_q) + 5'h01, 5'h00};
    end else begin
      slot_ms = NORMAL_SLOT_MS;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      xo_q       <= pcfg_pkg::XO_HUNT;
      slot_cnt_q <= 10'h000;
      mdix_sel   <= 1'b0;
    end else if (eng_rst) begin
      xo_q       <= pcfg_pkg::XO_HUNT;
      slot_cnt_q <= 10'h000;
      mdix_sel   <= 1'b0;
    end else begin
      unique case (xo_q)
        pcfg_pkg::XO_HUNT: begin
          if (link.energy_detect) begin
            xo_q       <= pcfg_pkg::XO_LOCK;
            slot_cnt_q <= 10'h000;
          end else if (slot_hit) begin
            mdix_sel   <= !mdix_sel;
            slot_cnt_q <= 10'h000;
          end else if (hunt_en && ms_tick) begin
            slot_cnt_q <= slot_cnt_q + 10'h001;
          end
        end
        pcfg_pkg::XO_LOCK: begin
          if (!link.energy_detect) begin
            xo_q <= pcfg_pkg::XO_HUNT;
          end
        end
      endcase
    end
  end

  // Duplex resolution.
  logic fd_force;

  assign fd_force = fd_q && link.partner_forced_100tx && (link.local_autoneg_en || link.local_forced_100tx);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      link_full_duplex <= 1'b0;
    end else begin
      link_full_duplex <= fd_force ? 1'b1 : link.ieee_full_duplex;
    end
  end

  // Test pair selection.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      test_pair_en <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        test_pair_en[i] <= tpair_sel_q[2] || (tpair_sel_q[1:0] == 2'(i));
      end
    end
  end

  // Interrupt status. A new event wins over a clear in the same cycle.
  assign events[pcfg_pkg::IRQ_CT_DONE_BIT] = ct_run_q && cable_test_finish && !eng_rst;
  assign events[pcfg_pkg::IRQ_CT_FAIL_BIT] = ct_run_q && cable_test_finish && cable_test_fault && !eng_rst;
  assign events[pcfg_pkg::IRQ_XO_LOCK_BIT] = xo_lock_ev;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stat_q <= '0;
      mask_q <= '0;
    end else if (full_rst_q) begin
      stat_q <= '0;
      mask_q <= '0;
    end else begin
      stat_q <= (stat_q & ~(wr_stat ? hwdata[pcfg_pkg::IRQ_W-1:0] : '0)) | events;
      if (wr_mask) begin
        mask_q <= hwdata[pcfg_pkg::IRQ_W-1:0];
      end
    end
  end

  // Shared pin. The pin is active low when it signals an interrupt, and a low input asks for power-down.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq                     <= 1'b0;
      irq_or_powerdown_pin_o  <= 1'b1;
      irq_or_powerdown_pin_oe <= 1'b0;
      powerdown_req           <= 1'b0;
    end else begin
      irq                     <= |(stat_q & mask_q);
      irq_or_powerdown_pin_o  <= !(force_q || |(stat_q & mask_q));
      irq_or_powerdown_pin_oe <= intoe_q;
      powerdown_req           <= !intoe_q && !irq_or_powerdown_pin_i;
    end
  end

  // Read data path.
  logic [15:0] rd16;

  always_comb begin
    rd16 = 16'h0000;
    unique case (cmd_q.idx)
      pcfg_pkg::CONF3_IDX: begin
        rd16[pcfg_pkg::CONF3_FD_BIT]     = fd_q;
        rd16[pcfg_pkg::CONF3_ROBUST_BIT] = robust_q;
        rd16[pcfg_pkg::CONF3_QUICK_BIT]  = quick_q;
        rd16[pcfg_pkg::CONF3_INTOE_BIT]  = intoe_q;
        rd16[pcfg_pkg::CONF3_FORCE_BIT]  = force_q;
        rd16[pcfg_pkg::CONF3_FAIL_BIT]   = ct_fail_q;
        rd16[pcfg_pkg::CONF3_DONE_BIT]   = ct_done_q;
        rd16[pcfg_pkg::CONF3_LAUNCH_BIT] = launch_q;
      end
      pcfg_pkg::CTRL_IDX: begin
        rd16[pcfg_pkg::CTRL_FULL_BIT]    = full_rst_q;
        rd16[pcfg_pkg::CTRL_RESTART_BIT] = restart_q;
      end
      pcfg_pkg::TPAIR_IDX:    rd16 = {pcfg_pkg::TPAIR_RSVD_RST, tpair_sel_q, 5'h00};
      pcfg_pkg::XTMR_IDX:     rd16 = {xtmr_rsvd_q, xtmr_code_q};
      pcfg_pkg::IRQ_STAT_IDX: rd16 = {13'h0000, stat_q};
      pcfg_pkg::IRQ_MASK_IDX: rd16 = {13'h0000, mask_q};
      default:                rd16 = 16'h0000;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hrdata_q <= 32'h0000_0000;
    end else if (cmd_q.rd) begin
      hrdata_q <= {16'h0000, rd16};
    end
  end

  assign hreadyout = hreadyout_q;
  assign hrdata    = hrdata_q;
  assign hresp     = 1'b0;

  // Checks.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  fd_forced_a: assert property (fd_force |=> link_full_duplex)
    else $error("forced full duplex not applied");
  fd_ieee_a: assert property (!fd_q |=> link_full_duplex == $past(link.ieee_full_duplex))
    else $error("duplex does not follow standard resolution");
  ct_done_low_a: assert property (ct_start |=> !ct_done_q && ct_run_q)
    else $error("test complete not cleared at launch");
  ct_result_a: assert property (ct_run_q && cable_test_finish && !eng_rst && !ct_start
                                |=> ct_done_q && (ct_fail_q == $past(cable_test_fault)))
    else $error("cable test result not latched");
  full_reset_a: assert property (wr_ctrl && hwdata[pcfg_pkg::CTRL_FULL_BIT] && !full_rst_q
                                 |=> full_rst_q ##1 (!full_rst_q && !fd_q && xtmr_code_q == 4'hf))
    else $error("full soft reset did not restore defaults");
  restart_keep_a: assert property (restart_q && !full_rst_q && !wr_conf3 && !wr_xtmr
                                   |=> $stable(fd_q) && $stable(xtmr_code_q) && !restart_q)
    else $error("soft restart changed registers");
  pair_sel_a: assert property (tpair_sel_q[2] |=> test_pair_en == 4'hf)
    else $error("all-pair test mode not driven");
  pair_one_a: assert property (!tpair_sel_q[2] && $stable(tpair_sel_q)
                               |=> test_pair_en == (4'h1 << $past(tpair_sel_q[1:0])))
    else $error("single pair selection wrong");
  rsvd_zero_a: assert property (cmd_q.rd && cmd_q.idx == pcfg_pkg::CONF3_IDX |=> hrdata[5:3] == 3'h0)
    else $error("reserved bits read nonzero");
  force_pin_a: assert property (force_q |=> !irq_or_powerdown_pin_o)
    else $error("forced interrupt not on pin");
  pin_role_a: assert property (##1 irq_or_powerdown_pin_oe == $past(intoe_q))
    else $error("pin role does not follow select bit");
  slot_toggle_a: assert property ($changed(mdix_sel) && !$past(eng_rst) |-> $past(slot_hit))
    else $error("crossover toggled outside slot end");
  stall_a: assert property (!hunt_en && xo_q == pcfg_pkg::XO_HUNT && !eng_rst |=> $stable(mdix_sel))
    else $error("normal mode hunted in deadlock pairing");

  ct_pass_c: cover property (ct_start ##[1:50] (cable_test_finish && !cable_test_fault));
  ct_fail_c: cover property (ct_start ##[1:50] (cable_test_finish && cable_test_fault));
  robust_c:  cover property (robust_q && deadlock && slot_hit);
  irq_c:     cover property (irq && !irq_or_powerdown_pin_o && irq_or_powerdown_pin_oe);
endmodule
`default_nettype wire

//--- testbench/testbench.sv
// Self-checking bench for the PHY configuration register bank.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int MSC = 10;
  localparam logic [7:0] C3 = pcfg_pkg::CONF3_IDX;
  localparam logic [7:0] CT = pcfg_pkg::CTRL_IDX;
  localparam logic [7:0] TP = pcfg_pkg::TPAIR_IDX;
  localparam logic [7:0] XT = pcfg_pkg::XTMR_IDX;
  localparam logic [7:0] ST = pcfg_pkg::IRQ_STAT_IDX;
  localparam logic [7:0] MK = pcfg_pkg::IRQ_MASK_IDX;
  logic                 clk = 1'b0;
  logic                 reset_n = 1'b0;
  logic                 hsel = 1'b0;
  logic [31:0]          haddr = 32'h0;
  logic [1:0]           htrans = 2'h0;
  logic                 hwrite = 1'b0;
  logic [31:0]          hwdata = 32'h0;
  logic                 hreadyout, hresp, pin_o, pin_oe, pdn, fdx, mdix, run, core_rst, irq;
  logic [31:0]          hrdata;
  logic [3:0]           pair_en;
  pcfg_pkg::pcfg_link_t link = '0;
  logic                 fin = 1'b0;
  logic                 fault = 1'b0;
  logic                 pin_i = 1'b1;
  int                   miscompares = 0;
  int                   checked = 0;
  logic [3:0]           pe;

  always #5 clk = ~clk;

  pcfg_regs #(.MS_CYCLES(MSC)) pcfg_regs_inst (
    .clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .link(link), .cable_test_finish(fin), .cable_test_fault(fault),
    .irq_or_powerdown_pin_i(pin_i), .irq_or_powerdown_pin_o(pin_o), .irq_or_powerdown_pin_oe(pin_oe),
    .powerdown_req(pdn), .link_full_duplex(fdx), .mdix_sel(mdix), .cable_test_run(run),
    .test_pair_en(pair_en), .core_reset(core_rst), .irq(irq));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Values read at the edge are the pre-edge ones, as the slave samples them.
  task automatic wait_ready;
    int k;
    k = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1) begin
      k++;
      if (k > 100) begin
        miscompares++;
        wrap_up();
      end
      @(posedge clk);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] idx, input logic [15:0] wd, output logic [31:0] got);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {22'h0, idx, 2'h0};
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {16'h0, wd};
    wait_ready();
    got = hrdata;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [15:0] d);
    logic [31:0] g;
    bus(1'b1, idx, d, g);
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] g;
    bus(1'b0, idx, 16'h0, g);
    check(g, exp);
  endtask

  // Measures one full crossover slot between two toggles of the selection.
  task automatic slot(input int exp);
    logic m;
    int   k;
    for (int n = 0; n < 2; n++) begin
      m = mdix;
      k = 0;
      while (mdix === m) begin
        @(posedge clk);
        k++;
        if (k > 20000) begin
          miscompares++;
          wrap_up();
        end
      end
    end
    check(32'(k), 32'(exp));
  endtask

  initial begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rdc(C3, 32'h2);
    rdc(CT, 32'h0);
    rdc(TP, 32'h400);
    rdc(XT, 32'h141f);
    rdc(8'h10, 32'h0);
    $display("defaults done");
    wr(C3, 16'h0bf8);
    rdc(C3, 32'h0bc2);
    check({31'h0, pin_oe}, 32'h1);
    check({31'h0, pin_o}, 32'h0);
    wr(C3, 16'h0000);
    pin_i <= 1'b0;
    repeat (3) @(posedge clk);
    check({31'h0, pdn}, 32'h1);
    pin_i <= 1'b1;
    $display("pin role done");
    link <= 5'b11000;
    repeat (3) @(posedge clk);
    check({31'h0, fdx}, 32'h0);
    link <= 5'b11010;
    repeat (3) @(posedge clk);
    check({31'h0, fdx}, 32'h1);
    link <= 5'b11000;
    wr(C3, 16'h0800);
    repeat (3) @(posedge clk);
    check({31'h0, fdx}, 32'h1);
    $display("duplex done");
    wr(C3, 16'h0001);
    rdc(C3, 32'h0001);
    check({31'h0, run}, 32'h1);
    fin <= 1'b1;
    fault <= 1'b1;
    @(posedge clk);
    fin <= 1'b0;
    fault <= 1'b0;
    repeat (2) @(posedge clk);
    rdc(C3, 32'h0007);
    rdc(ST, 32'h3);
    wr(MK, 16'h0001);
    repeat (3) @(posedge clk);
    check({31'h0, irq}, 32'h1);
    check({31'h0, pin_o}, 32'h0);
    wr(ST, 16'h0003);
    repeat (3) @(posedge clk);
    check({31'h0, irq}, 32'h0);
    check({31'h0, pin_o}, 32'h1);
    wr(C3, 16'h0001);
    fin <= 1'b1;
    @(posedge clk);
    fin <= 1'b0;
    rdc(C3, 32'h0003);
    $display("cable test done");
    for (int v = 0; v < 8; v++) begin
      wr(TP, 16'(v << 5));
      repeat (2) @(posedge clk);
      pe = v[2] ? 4'hf : 4'(1 << v[1:0]);
      check({28'h0, pair_en}, {28'h0, pe});
    end
    $display("test pairs done");
    wr(XT, 16'h0003);
    wr(CT, 16'h4000);
    @(posedge clk);
    check({31'h0, core_rst}, 32'h1);
    rdc(XT, 32'h3);
    rdc(CT, 32'h0);
    wr(CT, 16'h8000);
    rdc(XT, 32'h141f);
    rdc(C3, 32'h2);
    $display("soft resets done");
    link <= 5'b00000;
    slot(64 * MSC);
    wr(C3, 16'h0200);
    for (int c = 0; c < 4; c++) begin
      wr(XT, 16'(c));
      slot((c + 1) * 32 * MSC);
    end
    link <= 5'b11000;
    slot(4 * 32 * MSC);
    link <= 5'b10100;
    wr(C3, 16'h0100);
    slot(8 * MSC);
    link <= 5'b10101;
    repeat (2) @(posedge clk);
    rdc(ST, 32'h4);
    $display("crossover done");
    wrap_up();
  end

  initial begin
    #900000;
    miscompares++;
    wrap_up();
  end
endmodule
`default_nettype wire
